// ==== lef_pkg.sv ====
package lef_pkg;
	// Byte offsets of the registers on the APB port.
	localparam logic [7:0] LEF_STATUS_OFF = 8'h0C;
	localparam logic [7:0] LEF_MASK_OFF = 8'h10;
	localparam logic [7:0] LEF_CTRL_OFF = 8'h20;
	// Flag bit positions in the status and mask registers.
	localparam int LEF_SUM_BIT = 0;
	localparam int LEF_STUCK_BIT = 8;
	localparam int LEF_EMPTY_BIT = 9;
	localparam int LEF_REJ_BIT = 10;
	localparam int LEF_HDR_BIT = 11;
	localparam int LEF_TCODE_BIT = 12;
	localparam int LEF_ACK_BIT = 13;
	localparam int LEF_CYC_BIT = 15;
	localparam int LEF_RETRY_BIT = 16;
	localparam int LEF_ARB_BIT = 20;
	localparam int LEF_SUB_BIT = 21;
	localparam int LEF_LOG_BIT = 23;
	// Control register bit positions.
	localparam int LEF_CLR_BIT = 0;
	localparam int LEF_DIAG_BIT = 1;
	// Writable flag positions; reserved and foreign bits stay zero.
	localparam logic [31:0] LEF_FLAG_MASK = 32'h00B1_BF00;
	// Reset values.
	localparam logic [31:0] LEF_STATUS_RST = 32'h0000_0000;
	localparam logic [31:0] LEF_MASK_RST = 32'h8000_0000;
	localparam logic [31:0] LEF_ZERO = 32'h0000_0000;
	// Transmitter lock states, Gray coded.
	typedef enum logic [0:0] {
		LEF_TX_RUN = 1'b0,
		LEF_TX_STUCK = 1'b1
	} lef_tx_state_t;
endpackage

// ==== lef_link_event_flags.sv ====
`timescale 1ns/1ps
// Function
// RULE_01: Bad first quadlet entry sets stuck flag, state.
// RULE_02: Transmit queue underflow also causes stuck.
// RULE_03: Stuck blocks sends until queue clear bit.
// RULE_04: Empty flag set while transmit queue empty.
// RULE_05: Receive overflow busy acknowledge sets rejected flag.
// RULE_06: Header CRC error sets header flag.
// RULE_07: Invalid transaction code sets code flag.
// RULE_08: Acknowledge for queued packet sets flag.
// RULE_09: Cycle start sent or received sets flag.
// RULE_10: Retry limit reached sets retry flag.
// RULE_11: Arbitration reset gap idle sets flag.
// RULE_12: Subaction gap flag only in diagnostic mode.
// RULE_13: Login or logout completion sets flag.
// RULE_14: Flags clear only by writing one.
// RULE_15: Mask bit one lets flag interrupt.
// RULE_16: Summary bit is OR of masked flags.
// RULE_17: All flags zero after power up.
// RULE_18: Reserved bits read zero, ignore writes; the mask register stores and reads back all 32 bits, with bit 31 set at reset.
module lef_link_event_flags
	import lef_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic first_entry_bad,
	input wire logic tx_underflow,
	input wire logic tx_queue_is_empty,
	input wire logic rx_overflow_busy_ack,
	input wire logic rx_header_crc_err,
	input wire logic tx_bad_tcode,
	input wire logic tx_queue_ack,
	input wire logic tx_cycle_start,
	input wire logic rx_cycle_start,
	input wire logic retry_exhausted,
	input wire logic arb_gap_idle,
	input wire logic sub_gap_idle,
	input wire logic login_logout_done,
	output logic tx_stuck_hold,
	output logic tx_queue_clear_bit,
	output logic irq
);
	logic [31:0] status_q;
	logic [31:0] status_d;
	logic [31:0] mask_q;
	logic diag_q;
	logic clr_q;
	lef_tx_state_t tx_state_q;
	lef_tx_state_t tx_state_d;

	// Decoding of the APB access phase.
	wire access_w = psel && penable;
	wire wr_w = access_w && pwrite;
	wire hit_status = paddr == LEF_STATUS_OFF;
	wire hit_mask = paddr == LEF_MASK_OFF;
	wire hit_ctrl = paddr == LEF_CTRL_OFF;
	wire mapped = hit_status || hit_mask || hit_ctrl;
	wire wr_status = wr_w && hit_status;
	wire wr_mask = wr_w && hit_mask;
	wire wr_ctrl = wr_w && hit_ctrl;
	wire clr_req = wr_ctrl && pwdata[LEF_CLR_BIT];

	// Slave answers in the access cycle; unmapped addresses give an error.
	assign pready = 1'b1;
	assign pslverr = access_w && !mapped;

	// Event vector; every flag rides at its own bit position.
	logic [31:0] ev;
	always_comb begin
		ev = LEF_ZERO;
		ev[LEF_STUCK_BIT] = first_entry_bad || tx_underflow; // RULE_01 RULE_02
		ev[LEF_EMPTY_BIT] = tx_queue_is_empty; // RULE_04
		ev[LEF_REJ_BIT] = rx_overflow_busy_ack; // RULE_05
		ev[LEF_HDR_BIT] = rx_header_crc_err; // RULE_06
		ev[LEF_TCODE_BIT] = tx_bad_tcode; // RULE_07
		ev[LEF_ACK_BIT] = tx_queue_ack; // RULE_08
		ev[LEF_CYC_BIT] = tx_cycle_start || rx_cycle_start; // RULE_09
		ev[LEF_RETRY_BIT] = retry_exhausted; // RULE_10
		ev[LEF_ARB_BIT] = arb_gap_idle; // RULE_11
		ev[LEF_SUB_BIT] = sub_gap_idle && diag_q; // RULE_12
		ev[LEF_LOG_BIT] = login_logout_done; // RULE_13
	end

	// Write-one-to-clear, but a new event in the same cycle wins.
	wire [31:0] w1c = wr_status ? pwdata : LEF_ZERO;
	assign status_d = ((status_q & ~w1c) | ev) & LEF_FLAG_MASK; // RULE_14 RULE_18

	// Masked flags feed the summary bit and the interrupt line.
	wire [31:0] masked = status_q & mask_q & LEF_FLAG_MASK; // RULE_15
	wire summary = |masked; // RULE_16
	assign irq = summary;

	// Stuck state holds until firmware clears the transmit queue.
	always_comb begin
		tx_state_d = tx_state_q;
		case (tx_state_q)
			LEF_TX_RUN: begin
				if (ev[LEF_STUCK_BIT]) begin
					tx_state_d = LEF_TX_STUCK; // RULE_01 RULE_02
				end
			end
			LEF_TX_STUCK: begin
				if (clr_q && !ev[LEF_STUCK_BIT]) begin // Fresh fault wins.
					tx_state_d = LEF_TX_RUN; // RULE_03
				end
			end
			default: tx_state_d = LEF_TX_RUN;
		endcase
	end
	assign tx_stuck_hold = tx_state_q == LEF_TX_STUCK; // RULE_03
	assign tx_queue_clear_bit = clr_q;

	// Register state; power-up leaves every flag clear.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_q <= LEF_STATUS_RST; // RULE_17
			mask_q <= LEF_MASK_RST;
			diag_q <= 1'b0;
			clr_q <= 1'b0;
			tx_state_q <= LEF_TX_RUN;
		end else begin
			status_q <= status_d;
			if (wr_mask) begin
				mask_q <= pwdata;
			end
			if (wr_ctrl) begin
				diag_q <= pwdata[LEF_DIAG_BIT];
			end
			clr_q <= clr_req; // Self-clearing one-cycle pulse.
			tx_state_q <= tx_state_d;
		end
	end

	// Read data mux; the summary bit sits at bit 0 of the status word.
	logic [31:0] rd_sel;
	always_comb begin
		rd_sel = LEF_ZERO;
		if (hit_status) begin
			rd_sel = status_q;
			rd_sel[LEF_SUM_BIT] = summary; // RULE_16
		end else if (hit_mask) begin
			rd_sel = mask_q;
		end else if (hit_ctrl) begin
			rd_sel[LEF_DIAG_BIT] = diag_q;
		end
	end
	assign prdata = rd_sel;

	// Assertions.
	property p_stuck_enter;
		@(posedge pclk) disable iff (!presetn)
		(first_entry_bad || tx_underflow) |=>
			status_q[LEF_STUCK_BIT] && tx_stuck_hold;
	endproperty
	a_stuck_enter: assert property (p_stuck_enter) // RULE_01
		else $error("stuck missed");

	property p_stuck_hold;
		@(posedge pclk) disable iff (!presetn)
		(tx_stuck_hold && !clr_q) |=> tx_stuck_hold;
	endproperty
	a_stuck_hold: assert property (p_stuck_hold) // RULE_03
		else $error("stuck left");

	// Release takes two steps: the control write, then the clear pulse.
	sequence s_clear_write;
		wr_ctrl && pwdata[LEF_CLR_BIT] && !tx_underflow && !first_entry_bad;
	endsequence
	sequence s_clear_pulse;
		clr_q && !first_entry_bad && !tx_underflow;
	endsequence
	property p_stuck_release;
		@(posedge pclk) disable iff (!presetn)
		s_clear_write ##1 s_clear_pulse |=> !tx_stuck_hold;
	endproperty
	a_stuck_release: assert property (p_stuck_release) // RULE_03
		else $error("no release");

	property p_empty;
		@(posedge pclk) disable iff (!presetn)
		tx_queue_is_empty |=> status_q[LEF_EMPTY_BIT];
	endproperty
	a_empty: assert property (p_empty) // RULE_04
		else $error("empty missed");

	property p_cycle;
		@(posedge pclk) disable iff (!presetn)
		(tx_cycle_start || rx_cycle_start) |=> status_q[LEF_CYC_BIT];
	endproperty
	a_cycle: assert property (p_cycle) // RULE_09
		else $error("cycle missed");

	property p_subgap;
		@(posedge pclk) disable iff (!presetn)
		(!diag_q && !status_q[LEF_SUB_BIT]) |=> !status_q[LEF_SUB_BIT];
	endproperty
	a_subgap: assert property (p_subgap) // RULE_12
		else $error("subgap set");

	property p_sticky;
		@(posedge pclk) disable iff (!presetn)
		(status_q[LEF_HDR_BIT] && !(wr_status && pwdata[LEF_HDR_BIT]))
			|=> status_q[LEF_HDR_BIT];
	endproperty
	a_sticky: assert property (p_sticky) // RULE_14
		else $error("flag lost");

	property p_w1c;
		@(posedge pclk) disable iff (!presetn)
		(wr_status && pwdata[LEF_ACK_BIT] && !tx_queue_ack)
			|=> !status_q[LEF_ACK_BIT];
	endproperty
	a_w1c: assert property (p_w1c) // RULE_14
		else $error("clear failed");

	property p_irq;
		@(posedge pclk) disable iff (!presetn)
		irq == |(status_q & mask_q & LEF_FLAG_MASK);
	endproperty
	a_irq: assert property (p_irq) // RULE_15
		else $error("irq wrong");

	property p_reserved;
		@(posedge pclk) disable iff (!presetn)
		(status_q & ~LEF_FLAG_MASK) == LEF_ZERO;
	endproperty
	a_reserved: assert property (p_reserved) // RULE_18
		else $error("reserved set");

	// Every other source lands in its own flag one cycle later.
	property p_rejected;
		@(posedge pclk) disable iff (!presetn)
		rx_overflow_busy_ack |=> status_q[LEF_REJ_BIT];
	endproperty
	a_rejected: assert property (p_rejected) // RULE_05
		else $error("reject missed");

	property p_header;
		@(posedge pclk) disable iff (!presetn)
		rx_header_crc_err |=> status_q[LEF_HDR_BIT];
	endproperty
	a_header: assert property (p_header) // RULE_06
		else $error("header missed");

	property p_tcode;
		@(posedge pclk) disable iff (!presetn)
		tx_bad_tcode |=> status_q[LEF_TCODE_BIT];
	endproperty
	a_tcode: assert property (p_tcode) // RULE_07
		else $error("tcode missed");

	property p_ack;
		@(posedge pclk) disable iff (!presetn)
		tx_queue_ack |=> status_q[LEF_ACK_BIT];
	endproperty
	a_ack: assert property (p_ack) // RULE_08
		else $error("ack missed");

	property p_retry;
		@(posedge pclk) disable iff (!presetn)
		retry_exhausted |=> status_q[LEF_RETRY_BIT];
	endproperty
	a_retry: assert property (p_retry) // RULE_10
		else $error("retry missed");

	property p_arb;
		@(posedge pclk) disable iff (!presetn)
		arb_gap_idle |=> status_q[LEF_ARB_BIT];
	endproperty
	a_arb: assert property (p_arb) // RULE_11
		else $error("arb gap missed");

	property p_subgap_set;
		@(posedge pclk) disable iff (!presetn)
		(sub_gap_idle && diag_q) |=> status_q[LEF_SUB_BIT];
	endproperty
	a_subgap_set: assert property (p_subgap_set) // RULE_12
		else $error("subgap missed");

	property p_login;
		@(posedge pclk) disable iff (!presetn)
		login_logout_done |=> status_q[LEF_LOG_BIT];
	endproperty
	a_login: assert property (p_login) // RULE_13
		else $error("login missed");

	// A new event beats a write-one-to-clear in the same cycle.
	property p_set_wins;
		@(posedge pclk) disable iff (!presetn)
		(wr_status && pwdata[LEF_HDR_BIT] && rx_header_crc_err)
			|=> status_q[LEF_HDR_BIT];
	endproperty
	a_set_wins: assert property (p_set_wins) // RULE_14
		else $error("set lost");

	// A single-cycle strobe, so the queue clear never repeats by itself.
	property p_clear_pulse;
		@(posedge pclk) disable iff (!presetn)
		clr_q |=> !clr_q;
	endproperty
	a_clear_pulse: assert property (p_clear_pulse) // RULE_03
		else $error("clear stuck");

	property p_masked_quiet;
		@(posedge pclk) disable iff (!presetn)
		((status_q & mask_q & LEF_FLAG_MASK) == LEF_ZERO) |-> !irq;
	endproperty
	a_masked_quiet: assert property (p_masked_quiet) // RULE_15
		else $error("irq unmasked");

	property p_summary_read;
		@(posedge pclk) disable iff (!presetn)
		(access_w && hit_status) |-> prdata[LEF_SUM_BIT] == irq;
	endproperty
	a_summary_read: assert property (p_summary_read) // RULE_16
		else $error("summary wrong");

	property p_reserved_read;
		@(posedge pclk) disable iff (!presetn)
		(access_w && hit_status) |-> (prdata & ~LEF_FLAG_MASK
			& ~(32'h0000_0001 << LEF_SUM_BIT)) == LEF_ZERO;
	endproperty
	a_reserved_read: assert property (p_reserved_read) // RULE_18
		else $error("reserved read");
endmodule

// ==== tb.sv ====
`timescale 1ns/1ps
module tb;
	import lef_pkg::*;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rdat;
	logic pready, pslverr, tx_stuck_hold, tx_queue_clear_bit, irq, rerr;
	logic [12:0] ev = 13'h0000;
	int failures = 0, tests_run = 0, cyc = 0;
	int bt[13] = '{8, 8, 9, 10, 11, 12, 13, 15, 15, 16, 20, 21, 23};
	lef_link_event_flags DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.first_entry_bad(ev[0]), .tx_underflow(ev[1]),
		.tx_queue_is_empty(ev[2]), .rx_overflow_busy_ack(ev[3]),
		.rx_header_crc_err(ev[4]), .tx_bad_tcode(ev[5]),
		.tx_queue_ack(ev[6]), .tx_cycle_start(ev[7]),
		.rx_cycle_start(ev[8]), .retry_exhausted(ev[9]),
		.arb_gap_idle(ev[10]), .sub_gap_idle(ev[11]),
		.login_logout_done(ev[12]), .tx_stuck_hold(tx_stuck_hold),
		.tx_queue_clear_bit(tx_queue_clear_bit), .irq(irq));
	// Free running clock at 125 MHz.
	always #4 pclk = ~pclk;
	task summarize;
		if (failures == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// A hang must not hide behind a silent run, so a cycle ceiling ends it.
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			summarize;
		end
	end
	task chk(input string n, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", n, exp, got);
			failures++;
		end
	endtask
	// One APB transfer; the answer is taken at the edge that sees pready.
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk("prdata", exp, rdat);
		chk("pslverr", 32'h0000_0000, rerr);
	endtask
	// The event is sampled high at exactly one edge.
	task pulse(input int i);
		@(posedge pclk);
		ev[i] <= 1'b1;
		@(posedge pclk);
		ev <= 13'h0000;
	endtask
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		rd(LEF_STATUS_OFF, 32'h0000_0000);
		rd(LEF_MASK_OFF, LEF_MASK_RST);
		pulse(11);
		rd(LEF_STATUS_OFF, 32'h0000_0000);
		apb(1'b1, LEF_CTRL_OFF, 32'h0000_0002);
		for (int i = 0; i < 13; i++) begin
			pulse(i);
			rd(LEF_STATUS_OFF, 32'h0000_0001 << bt[i]);
			apb(1'b1, LEF_STATUS_OFF, 32'h0000_0000);
			rd(LEF_STATUS_OFF, 32'h0000_0001 << bt[i]);
			if (i < 2) begin
				chk("hold", 32'h0000_0001, tx_stuck_hold);
				apb(1'b1, LEF_CTRL_OFF, 32'h0000_0003);
				@(negedge pclk);
				chk("clear", 32'h0000_0001, tx_queue_clear_bit);
				chk("hold", 32'h0000_0001, tx_stuck_hold);
				@(negedge pclk);
				chk("clear", 32'h0000_0000, tx_queue_clear_bit);
				chk("hold", 32'h0000_0000, tx_stuck_hold);
			end
			apb(1'b1, LEF_STATUS_OFF, 32'h0000_0001 << bt[i]);
			rd(LEF_STATUS_OFF, 32'h0000_0000);
		end
		// Masked and unmasked flags reach the interrupt line differently.
		apb(1'b1, LEF_MASK_OFF, 32'h8001_0000);
		pulse(9);
		@(negedge pclk);
		chk("irq", 32'h0000_0001, irq);
		rd(LEF_STATUS_OFF, 32'h0001_0001);
		apb(1'b1, LEF_STATUS_OFF, 32'h0001_0000);
		pulse(12);
		@(negedge pclk);
		chk("irq", 32'h0000_0000, irq);
		rd(LEF_STATUS_OFF, 32'h0080_0000);
		// Every source at once; reserved places stay zero.
		@(posedge pclk);
		ev <= 13'h1FFF;
		@(posedge pclk);
		ev <= 13'h0000;
		rd(LEF_STATUS_OFF, 32'h00B1_BF01);
		apb(1'b1, LEF_STATUS_OFF, 32'hFFFF_FFFF);
		rd(LEF_STATUS_OFF, 32'h0000_0000);
		apb(1'b0, 8'h40, 32'h0000_0000);
		chk("unmapped", 32'h0000_0000, rdat);
		chk("pslverr", 32'h0000_0001, rerr);
		summarize;
	end
endmodule
